// *** pkg/cwd_defs.svh ***
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH

// word geometry and register indices (byte address = index * 4)
`define CWD_WORD_W         14
`define CWD_IDX_W          14
`define CWD_IDX_STATUS     14'h0000
`define CWD_IDX_CONTROL    14'h0001
`define CWD_IDX_WORD_ONE   14'h2007
`define CWD_IDX_WORD_TWO   14'h2008

// erased value and bits that read as one on a word read in programming mode
`define CWD_ERASED_WORD    14'h3fff
`define CWD_UNIMPL_ONE     14'h0880
`define CWD_UNIMPL_TWO     14'h3fcf

// word one fields
`define CWD_OSC_LSB        0
`define CWD_OSC_MSB        2
`define CWD_WATCHDOG_BIT   3
`define CWD_POWERUP_N_BIT  4
`define CWD_RESETPIN_BIT   5
`define CWD_PROTECT_BIT    6
`define CWD_BROWNOUT_LSB   8
`define CWD_BROWNOUT_MSB   9
`define CWD_BROWNVSEL_BIT  10
`define CWD_MULTIPLIER_BIT 12
`define CWD_DEBUG_BIT      13

// word two fields
`define CWD_REGCAP_LSB     4
`define CWD_REGCAP_MSB     5

// regulator capacitor pin codes
`define CWD_REGCAP_PA0     2'h0
`define CWD_REGCAP_PA5     2'h1
`define CWD_REGCAP_PA6     2'h2
`define CWD_REGCAP_NONE    2'h3

// brown-out field codes
`define CWD_BROWNOUT_RUN   2'h2
`define CWD_BROWNOUT_ON    2'h3

// control bit position and bus data width
`define CWD_CTRL_ERASE_ACK 0
`define CWD_DATA_W         32

`endif

// *** pkg/cwd_pkg.sv ***
package cwd_pkg;

  // oscillator select codes, values as stored in word one
  typedef enum logic [2:0] {
    OSC_RC_OSCILLATOR_DIVIDED_CLOCK_OUTPUT       = 3'h7,
    OSC_RC_OSCILLATOR_IO           = 3'h6,
    OSC_INTERNAL_OSCILLATOR_DIVIDED_CLOCK_OUTPUT = 3'h5,
    OSC_INTERNAL_OSCILLATOR_IO     = 3'h4,
    OSC_EXTERNAL_CLOCK_INPUT       = 3'h3,
    OSC_HIGH_SPEED_CRYSTAL         = 3'h2,
    OSC_MEDIUM_CRYSTAL             = 3'h1,
    OSC_LOW_POWER_CRYSTAL          = 3'h0
  } cwd_osc_mode_t;

  // bus answer sequence, gray coded
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_FETCH  = 2'b01,
    BUS_ANSWER = 2'b11
  } cwd_bus_state_t;

  // decoded start-up settings
  typedef struct packed {
    cwd_osc_mode_t oscMode;
    logic          clkoutOnOsc2;
    logic          osc2IsIo;
    logic          osc1IsIo;
    logic          crystalMode;
    logic [1:0]    crystalGain;
    logic          oscMultiplierEnable;
    logic          watchdogEnable;
    logic          powerupTimerEnable;
    logic          brownoutEnable;
    logic          brownoutInSleep;
    logic          brownoutVoltageSelect;
    logic          resetPinIsReset;
    logic          codeProtect;
    logic          debugEnable;
    logic [2:0]    regCapPinOneHot;
  } cwd_settings_t;

endpackage

// *** core/cwd_word_store.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cwd_defs.svh"

module cwd_word_store (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // write port
  input  wire logic                     wrEn,
  input  wire logic                     wrSel,
  input  wire logic [`CWD_WORD_W-1:0]   wrData,
  // registered read port
  input  wire logic                     rdSel,
  output logic      [`CWD_WORD_W-1:0]   rdData,
  // both words for decoding
  output logic      [`CWD_WORD_W-1:0]   wordOne,
  output logic      [`CWD_WORD_W-1:0]   wordTwo
);

  logic [`CWD_WORD_W-1:0] word_ff [2];
  logic [`CWD_WORD_W-1:0] rdData_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_ff[0] <= `CWD_ERASED_WORD;
      word_ff[1] <= `CWD_ERASED_WORD;
    end else if (wrEn) begin
      word_ff[wrSel] <= wrData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_ff <= `CWD_ERASED_WORD;
    end else begin
      rdData_ff <= word_ff[rdSel];
    end
  end

  assign rdData  = rdData_ff;
  assign wordOne = word_ff[0];
  assign wordTwo = word_ff[1];

endmodule // cwd_word_store

`default_nettype wire

// *** core/cwd_config_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cwd_defs.svh"

module cwd_config_decoder (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // avalon-mm slave
  input  wire logic [15:0]              avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [`CWD_DATA_W-1:0]   avs_writedata,
  output logic      [`CWD_DATA_W-1:0]   avs_readdata,
  output logic                          avs_waitrequest,
  // device pins and straps
  input  wire logic                     programmingMode,
  input  wire logic                     externalResetPin_n,
  input  wire logic                     lowVoltageVariant,
  // decoded settings toward oscillator, reset, watchdog, regulator
  output cwd_pkg::cwd_settings_t        settings,
  output logic                          internalOscDisable,
  output logic                          eraseProgramMemory
);

  import cwd_pkg::*;

  // pin synchronisers
  logic [1:0] progSync_ff;
  logic [1:0] resetPinSync_ff;
  logic [1:0] lowVoltSync_ff;
  logic       progMode;
  logic       resetPinAsserted;
  logic       lowVolt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      progSync_ff     <= 2'h0;
      resetPinSync_ff <= 2'h3;
      lowVoltSync_ff  <= 2'h0;
    end else begin
      progSync_ff     <= {progSync_ff[0], programmingMode};
      resetPinSync_ff <= {resetPinSync_ff[0], externalResetPin_n};
      lowVoltSync_ff  <= {lowVoltSync_ff[0], lowVoltageVariant};
    end
  end

  assign progMode         = progSync_ff[1];
  assign resetPinAsserted = ~resetPinSync_ff[1];
  assign lowVolt          = lowVoltSync_ff[1];

  // address decode
  logic [`CWD_IDX_W-1:0] reqIdx;
  logic                  aligned;
  logic                  hitWordOne;
  logic                  hitWordTwo;
  logic                  hitWord;
  logic                  hitStatus;
  logic                  hitControl;

  assign reqIdx     = avs_address[15:2];
  assign aligned    = (avs_address[1:0] == 2'h0);
  assign hitWordOne = aligned && (reqIdx == `CWD_IDX_WORD_ONE);
  assign hitWordTwo = aligned && (reqIdx == `CWD_IDX_WORD_TWO);
  assign hitWord    = hitWordOne || hitWordTwo;
  assign hitStatus  = aligned && (reqIdx == `CWD_IDX_STATUS);
  assign hitControl = aligned && (reqIdx == `CWD_IDX_CONTROL);

  // bus answer sequence: fetch one cycle, answer the next
  cwd_bus_state_t busState_ff;
  cwd_bus_state_t nxt_busState;
  logic           request;
  logic           commit;

  assign request = avs_read || avs_write;
  assign commit  = (busState_ff == BUS_ANSWER) && request;

  always_comb begin
    case (busState_ff)
      BUS_IDLE:   nxt_busState = request ? BUS_FETCH : BUS_IDLE;
      BUS_FETCH:  nxt_busState = request ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: nxt_busState = BUS_IDLE;
      default:    nxt_busState = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busState_ff <= BUS_IDLE;
    end else begin
      busState_ff <= nxt_busState;
    end
  end

  assign avs_waitrequest = request && (busState_ff != BUS_ANSWER);

  // word storage
  logic [`CWD_WORD_W-1:0] storeRd;
  logic [`CWD_WORD_W-1:0] wordOne;
  logic [`CWD_WORD_W-1:0] wordTwo;
  logic                   wordWrite;
  logic [`CWD_WORD_W-1:0] wordWrData;

  // no path to the words outside programming mode
  assign wordWrite  = commit && avs_write && hitWord && progMode;
  assign wordWrData = avs_writedata[`CWD_WORD_W-1:0];

  cwd_word_store u_store (
    .clk     (clk),
    .reset   (reset),
    .wrEn    (wordWrite),
    .wrSel   (hitWordTwo),
    .wrData  (wordWrData),
    .rdSel   (hitWordTwo),
    .rdData  (storeRd),
    .wordOne (wordOne),
    .wordTwo (wordTwo)
  );

  // unimplemented positions forced to one on readback
  function automatic logic [`CWD_WORD_W-1:0] withFill(
    input logic [`CWD_WORD_W-1:0] raw,
    input logic                   second
  );
    withFill = raw | (second ? `CWD_UNIMPL_TWO : `CWD_UNIMPL_ONE);
  endfunction

  // protection lifted: erase request stays until acknowledged
  logic erasePending_ff;
  logic protectLifted;
  logic eraseAck;

  assign protectLifted = wordWrite && !hitWordTwo
                      && !wordOne[`CWD_PROTECT_BIT]
                      && wordWrData[`CWD_PROTECT_BIT];
  assign eraseAck      = commit && avs_write && hitControl
                      && avs_writedata[`CWD_CTRL_ERASE_ACK];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      erasePending_ff <= 1'b0;
    end else if (protectLifted) begin
      erasePending_ff <= 1'b1;
    end else if (eraseAck) begin
      erasePending_ff <= 1'b0;
    end
  end

  assign eraseProgramMemory = erasePending_ff;

  // decode of both words into settings
  function automatic cwd_settings_t decodeWords(
    input logic [`CWD_WORD_W-1:0] one,
    input logic [`CWD_WORD_W-1:0] two,
    input logic                   noRegulator
  );
    cwd_settings_t s;
    logic [1:0]    brownCode;
    logic [1:0]    capCode;
    s         = '0;
    brownCode = one[`CWD_BROWNOUT_MSB:`CWD_BROWNOUT_LSB];
    capCode   = two[`CWD_REGCAP_MSB:`CWD_REGCAP_LSB];
    s.oscMode = cwd_osc_mode_t'(one[`CWD_OSC_MSB:`CWD_OSC_LSB]);
    case (s.oscMode)
      OSC_RC_OSCILLATOR_DIVIDED_CLOCK_OUTPUT: begin
        s.clkoutOnOsc2 = 1'b1;
      end
      OSC_RC_OSCILLATOR_IO: begin
        s.osc2IsIo = 1'b1;
      end
      OSC_INTERNAL_OSCILLATOR_DIVIDED_CLOCK_OUTPUT: begin
        s.clkoutOnOsc2 = 1'b1;
        s.osc1IsIo     = 1'b1;
      end
      OSC_INTERNAL_OSCILLATOR_IO: begin
        s.osc2IsIo = 1'b1;
        s.osc1IsIo = 1'b1;
      end
      OSC_EXTERNAL_CLOCK_INPUT: begin
        s.osc2IsIo = 1'b1;
      end
      OSC_HIGH_SPEED_CRYSTAL: begin
        s.crystalMode = 1'b1;
        s.crystalGain = 2'h2;
      end
      OSC_MEDIUM_CRYSTAL: begin
        s.crystalMode = 1'b1;
        s.crystalGain = 2'h1;
      end
      OSC_LOW_POWER_CRYSTAL: begin
        s.crystalMode = 1'b1;
        s.crystalGain = 2'h0;
      end
      default: begin
        s.crystalMode = 1'b0;
      end
    endcase
    s.oscMultiplierEnable   = one[`CWD_MULTIPLIER_BIT];
    s.watchdogEnable        = one[`CWD_WATCHDOG_BIT];
    // timer follows its own bit only, whatever brown-out says
    s.powerupTimerEnable    = !one[`CWD_POWERUP_N_BIT];
    s.brownoutEnable        = brownCode[1];
    s.brownoutInSleep       = (brownCode == `CWD_BROWNOUT_ON);
    s.brownoutVoltageSelect = one[`CWD_BROWNVSEL_BIT];
    s.resetPinIsReset       = one[`CWD_RESETPIN_BIT];
    s.codeProtect           = !one[`CWD_PROTECT_BIT];
    s.debugEnable           = !one[`CWD_DEBUG_BIT];
    if (noRegulator) begin
      s.regCapPinOneHot = 3'h0;
    end else begin
      case (capCode)
        `CWD_REGCAP_PA0:  s.regCapPinOneHot = 3'h1;
        `CWD_REGCAP_PA5:  s.regCapPinOneHot = 3'h2;
        `CWD_REGCAP_PA6:  s.regCapPinOneHot = 3'h4;
        `CWD_REGCAP_NONE: s.regCapPinOneHot = 3'h0;
        default:          s.regCapPinOneHot = 3'h0;
      endcase
    end
    decodeWords = s;
  endfunction

  // settings latched only while out of programming mode
  cwd_settings_t settings_ff;
  cwd_settings_t nxt_settings;

  assign nxt_settings = decodeWords(wordOne, wordTwo, lowVolt);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settings_ff <= decodeWords(`CWD_ERASED_WORD, `CWD_ERASED_WORD, 1'b0);
    end else if (!progMode) begin
      settings_ff <= nxt_settings;
    end
  end

  assign settings = settings_ff;

  // internal or RC oscillator held off under external reset
  logic oscDisable_ff;
  logic internalOrRc;

  assign internalOrRc = settings_ff.oscMode[2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscDisable_ff <= 1'b0;
    end else begin
      oscDisable_ff <= resetPinAsserted && settings_ff.resetPinIsReset
                    && internalOrRc;
    end
  end

  assign internalOscDisable = oscDisable_ff;

  // status word
  logic [`CWD_DATA_W-1:0] statusWord;

  assign statusWord = {21'h0,
                       settings_ff.oscMode,
                       settings_ff.brownoutEnable,
                       settings_ff.powerupTimerEnable,
                       settings_ff.watchdogEnable,
                       erasePending_ff,
                       oscDisable_ff,
                       resetPinAsserted,
                       lowVolt,
                       progMode};

  // read data, captured at the fetch cycle
  logic [`CWD_DATA_W-1:0] readData_ff;
  logic                   fetchRead;

  assign fetchRead = (busState_ff == BUS_FETCH) && avs_read;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readData_ff <= '0;
    end else if (fetchRead) begin
      if (hitWord && progMode) begin
        readData_ff <= {18'h0, withFill(storeRd, hitWordTwo)};
      end else if (hitStatus) begin
        readData_ff <= statusWord;
      end else begin
        readData_ff <= '0;
      end
    end
  end

  assign avs_readdata = readData_ff;

endmodule // cwd_config_decoder

`default_nettype wire

// *** test/cwd_config_decoder_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module cwd_config_decoder_asserts (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // register bus
  input wire logic [15:0]            avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // pins and decoded outputs
  input wire logic                   programmingMode,
  input wire logic                   externalResetPin_n,
  input wire logic                   lowVoltageVariant,
  input wire cwd_pkg::cwd_settings_t settings,
  input wire logic                   internalOscDisable,
  input wire logic                   eraseProgramMemory
);
  import cwd_pkg::*;
  wire logic req  = avs_read | avs_write;
  wire logic done = req & ~avs_waitrequest;
  wire logic wOne = avs_address == 16'h801c;
  wire logic wTwo = avs_address == 16'h8020;
  wire logic setW = done & avs_write & wOne & avs_writedata[6];
  wire logic ackW = done & avs_write & (avs_address == 16'h0004) & avs_writedata[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wait2;
    avs_waitrequest [*2] ##1 !avs_waitrequest;
  endsequence
  sequence s_locked;
    !programmingMode [*6];
  endsequence
  bus_answer_a: assert property (
    req && !$past(req) |-> s_wait2) else $error("bus answer not after two waits");
  word_lock_a: assert property (
    s_locked ##0 (done && avs_read && (wOne || wTwo)) |-> avs_readdata == 32'h0)
    else $error("word read outside programming");
  fill_one_a: assert property (
    done && avs_read && wOne && avs_readdata != 0 |-> (avs_readdata & 32'hffffc880) == 32'h880)
    else $error("word one filler bits wrong");
  fill_two_a: assert property (
    done && avs_read && wTwo && avs_readdata != 0 |-> (avs_readdata & 32'hffffffcf) == 32'h3fcf)
    else $error("word two filler bits wrong");
  erase_cause_a: assert property (
    $rose(eraseProgramMemory) |-> $past(setW) || $past(setW, 2))
    else $error("erase without write");
  erase_clear_a: assert property (
    $fell(eraseProgramMemory) |-> $past(ackW) || $past(ackW, 2))
    else $error("erase dropped early");
  osc_rc_a: assert property (
    settings.oscMode[2:1] == 2'b11 |-> !settings.osc1IsIo && !settings.crystalMode
      && settings.osc2IsIo == !settings.oscMode[0] && settings.clkoutOnOsc2 == settings.oscMode[0])
    else $error("rc pin use wrong");
  osc_int_a: assert property (
    settings.oscMode[2:1] == 2'b10 |-> settings.osc1IsIo && !settings.crystalMode
      && settings.osc2IsIo == !settings.oscMode[0] && settings.clkoutOnOsc2 == settings.oscMode[0])
    else $error("internal pin use wrong");
  osc_xtal_a: assert property (
    !settings.oscMode[2] |-> !settings.osc1IsIo && !settings.clkoutOnOsc2
      && settings.crystalMode == (settings.oscMode != 3'h3)
      && settings.osc2IsIo == (settings.oscMode == 3'h3))
    else $error("crystal or external pin use wrong");
  osc_off_a: assert property (
    (!externalResetPin_n && settings.oscMode[2] && settings.resetPinIsReset) [*4]
      |=> internalOscDisable)
    else $error("oscillator not stopped");
  regcap_lv_a: assert property (
    (lowVoltageVariant && !programmingMode) [*5] |=> settings.regCapPinOneHot == 3'h0)
    else $error("regulator pin on low-voltage part");
endmodule // cwd_config_decoder_asserts
`default_nettype wire

// *** test/cwd_programmer.sv ***
`timescale 1ns/1ns
`default_nettype none
module cwd_programmer (
  // bus answer
  input  wire logic        clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  // bus request
  output var logic  [15:0] avs_address,
  output var logic         avs_read,
  output var logic         avs_write,
  output var logic  [31:0] avs_writedata,
  // programming entry
  output var logic         programmingMode
);
  initial begin
    avs_address = 16'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    programmingMode = 1'b0;
  end
  // words only touched after the mode pin has passed the syncs
  task automatic mode(input logic on);
    @(posedge clk);
    programmingMode <= on;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
endmodule // cwd_programmer
`default_nettype wire

// *** test/tb_config_word_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_config_word_decoder;
  import cwd_pkg::*;
  logic          clk, reset, externalResetPin_n, lowVoltageVariant, programmingMode;
  logic [15:0]   avs_address;
  logic          avs_read, avs_write, avs_waitrequest;
  logic [31:0]   avs_writedata, avs_readdata, rdat;
  logic          internalOscDisable, eraseProgramMemory;
  cwd_settings_t settings;
  int            fails, comparisons, cycles;

  cwd_config_decoder uut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .programmingMode(programmingMode), .externalResetPin_n(externalResetPin_n),
    .lowVoltageVariant(lowVoltageVariant), .settings(settings),
    .internalOscDisable(internalOscDisable), .eraseProgramMemory(eraseProgramMemory));
  cwd_programmer prog (.clk(clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .programmingMode(programmingMode));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rdchk(input string n, input logic [15:0] a, input logic [31:0] e);
    prog.rd(a, rdat);
    chk(n, rdat, e);
  endtask
  // program both words, then leave programming so settings follow
  task automatic setup(input logic [13:0] one, input logic [13:0] two);
    prog.mode(1'b1);
    prog.wr(16'h801c, {18'h0, one});
    prog.wr(16'h8020, {18'h0, two});
    prog.mode(1'b0);
    repeat (3) @(posedge clk);
  endtask

  initial begin
    reset = 1'b1;
    externalResetPin_n = 1'b1;
    lowVoltageVariant = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    chk("boot", 32'({settings.oscMode, settings.watchdogEnable, settings.powerupTimerEnable,
      settings.brownoutEnable, settings.resetPinIsReset, settings.regCapPinOneHot}),
      32'h3d8);
    rdchk("stat", 16'h0000, 32'h7a0);
    prog.wr(16'h801c, 32'h0);
    rdchk("lock", 16'h801c, 32'h0);
    prog.mode(1'b1);
    rdchk("one", 16'h801c, 32'h3fff);
    prog.wr(16'h801c, 32'h0);
    prog.wr(16'h8020, 32'h0);
    rdchk("fill1", 16'h801c, 32'h880);
    rdchk("fill2", 16'h8020, 32'h3fcf);
    rdchk("odd", 16'h801d, 32'h0);
    rdchk("hole", 16'h0010, 32'h0);
    chk("keep", 32'(eraseProgramMemory), 32'h0);
    prog.wr(16'h801c, 32'h3fff);
    repeat (2) @(posedge clk);
    chk("erase", 32'(eraseProgramMemory), 32'h1);
    rdchk("stat2", 16'h0000, 32'h7b1);
    prog.wr(16'h0004, 32'h1);
    prog.wr(16'h801c, 32'h3fff);
    repeat (2) @(posedge clk);
    chk("ack", 32'(eraseProgramMemory), 32'h0);
    for (int c = 0; c < 8; c++) begin
      setup({c[0], c[2], 1'b1, c[1], c[2], c[0], 1'b1, c[1], 1'b1, c[1], c[0], c[2:0]},
        {8'hff, c[1:0], 4'hf});
      chk("osc", 32'({settings.oscMode, settings.clkoutOnOsc2, settings.osc2IsIo,
        settings.osc1IsIo, settings.crystalMode, settings.crystalGain}), 32'({c[2:0],
        c == 7 || c == 5, c == 6 || c == 4 || c == 3, c == 5 || c == 4, c < 3,
        c < 3 ? c[1:0] : 2'h0}));
      chk("ctl", 32'({settings.watchdogEnable, settings.powerupTimerEnable,
        settings.brownoutEnable, settings.brownoutInSleep, settings.brownoutVoltageSelect,
        settings.oscMultiplierEnable, settings.debugEnable, settings.codeProtect}),
        32'({c[0], !c[1], c[2], c[2] & c[0],
        c[1], c[2], !c[0], !c[1]}));
      chk("cap", 32'(settings.regCapPinOneHot),
        32'(c[1:0] == 3 ? 0 : 1 << c[1:0]));
      externalResetPin_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("oscoff", 32'(internalOscDisable), 32'(c[2]));
      externalResetPin_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
    chk("erase2", 32'(eraseProgramMemory), 32'h1);
    setup(14'h3fff, 14'h3fcf);
    lowVoltageVariant <= 1'b1;
    repeat (6) @(posedge clk);
    chk("lv", 32'(settings.regCapPinOneHot), 32'h0);
    lowVoltageVariant <= 1'b0;
    repeat (6) @(posedge clk);
    chk("hv", 32'(settings.regCapPinOneHot), 32'h1);
    close_out();
  end
endmodule // tb_config_word_decoder

bind cwd_config_decoder cwd_config_decoder_asserts chk_i (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .programmingMode(programmingMode),
  .externalResetPin_n(externalResetPin_n), .lowVoltageVariant(lowVoltageVariant),
  .settings(settings), .internalOscDisable(internalOscDisable),
  .eraseProgramMemory(eraseProgramMemory));
`default_nettype wire
